// File: clee_pkg.sv
package clee_pkg;

   // Default sizing of the equation bank
   localparam int NUM_EQ_DEF = 8;
   localparam int NUM_EXT_DEF = 16;
   localparam int NUM_IN = 4;

   // Source select and timer field widths
   localparam int SEL_W = 6;
   localparam int TMR_W = 16;
   localparam int SRC_MAX = 64;

   // Source list layout: external signals, then unlatched, then latched
   localparam int SRC_EXT_BASE = 0;

   // Reset values
   localparam logic [TMR_W-1:0] CNT_RST = 16'h0000;
   localparam logic [SEL_W-1:0] SEL_RST = 6'h00;

   // Gate operators
   typedef enum logic [1:0] {
      CLEE_AND = 2'h0,
      CLEE_OR = 2'h1,
      CLEE_NAND = 2'h2,
      CLEE_NOR = 2'h3
   } clee_gate_e;

   // Per-equation configuration
   typedef struct packed {
      logic [NUM_IN-1:0][SEL_W-1:0] inSel;
      logic [NUM_IN-1:0] inInv;
      clee_gate_e gateOp;
      logic [TMR_W-1:0] riseDelayTime;
      logic [TMR_W-1:0] fallDelayTime;
      logic [SEL_W-1:0] rstSel;
      logic rstInv;
   } clee_cfg_s;

endpackage

// File: clee_engine.sv
`timescale 1ns/1ps
module clee_engine #(
   parameter int NUM_EQ = clee_pkg::NUM_EQ_DEF,
   parameter int NUM_EXT = clee_pkg::NUM_EXT_DEF
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [NUM_EXT-1:0] extSignal,
   input wire clee_pkg::clee_cfg_s eqCfg [NUM_EQ],
   output logic [NUM_EQ-1:0] eqOut,
   output logic [NUM_EQ-1:0] eqLatched,
   output logic [NUM_EQ-1:0] eqLatchedN,
   output logic [NUM_EQ-1:0][clee_pkg::NUM_IN-1:0] eqInState,
   output logic [NUM_EQ-1:0] eqGateState,
   output logic [$clog2(NUM_EQ)-1:0] evalIndex,
   output logic cycleDone
);

   localparam int IDX_W = $clog2(NUM_EQ);
   localparam int SRC_N = NUM_EXT + 2 * NUM_EQ;
   localparam int SRC_OUT_BASE = clee_pkg::SRC_EXT_BASE + NUM_EXT;
   localparam int SRC_LAT_BASE = SRC_OUT_BASE + NUM_EQ;
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NUM_EQ - 1);

   // Elaboration check
   if (NUM_EQ < 2 || NUM_EXT < 1 || SRC_N > clee_pkg::SRC_MAX)
   begin : g_bad_size
      $error("clee_engine: unsupported NUM_EQ or NUM_EXT");
   end

   // Source lookup; selects beyond the list read as zero
   function automatic logic pickSrc(
      input logic [clee_pkg::SRC_MAX-1:0] vec,
      input logic [clee_pkg::SEL_W-1:0] sel
   );
      return vec[sel];
   endfunction

   // Gate operator
   function automatic logic gateEval(
      input clee_pkg::clee_gate_e op,
      input logic [clee_pkg::NUM_IN-1:0] cond
   );
      logic res;
      res = 1'b0;
      unique case (op)
         clee_pkg::CLEE_AND: res = &cond;
         clee_pkg::CLEE_OR: res = |cond;
         clee_pkg::CLEE_NAND: res = ~&cond;
         clee_pkg::CLEE_NOR: res = ~|cond;
      endcase
      return res;
   endfunction

   logic [IDX_W-1:0] evalIdx_q;
   logic [IDX_W-1:0] prevIdx_q;
   logic [NUM_EQ-1:0] eqOut_q;
   logic [NUM_EQ-1:0] eqLat_q;
   logic [NUM_EQ-1:0] eqGate_q;
   logic [NUM_EQ-1:0][clee_pkg::NUM_IN-1:0] eqIn_q;
   logic [clee_pkg::TMR_W-1:0] eqCnt_q [NUM_EQ];
   logic cycleDone_q;

   logic [clee_pkg::SRC_MAX-1:0] srcVec;
   clee_pkg::clee_cfg_s cfg;
   logic [clee_pkg::NUM_IN-1:0] condIn;
   logic gate;
   logic curOut;
   logic [clee_pkg::TMR_W-1:0] curCnt;
   logic [clee_pkg::TMR_W-1:0] curDelay;
   logic expire;
   logic nextOut;
   logic rstCond;
   logic nextLatch;
   logic [clee_pkg::TMR_W-1:0] cnt_d;

   // Source list sees results already written this pass
   always_comb
   begin
      srcVec = '0;
      srcVec[SRC_N-1:0] = {eqLat_q, eqOut_q, extSignal};
   end

   // Evaluation of the equation under the index
   always_comb
   begin
      cfg = eqCfg[evalIdx_q];
      for (int k = 0; k < clee_pkg::NUM_IN; k++)
      begin
         condIn[k] = pickSrc(srcVec, cfg.inSel[k]) ^ cfg.inInv[k];
      end
      gate = gateEval(cfg.gateOp, condIn);
      curOut = eqOut_q[evalIdx_q];
      curCnt = eqCnt_q[evalIdx_q];
      curDelay = gate ? cfg.riseDelayTime : cfg.fallDelayTime;
      expire = curCnt >= curDelay;
      nextOut = (gate != curOut && expire) ? gate : curOut;
      rstCond = pickSrc(srcVec, cfg.rstSel) ^ cfg.rstInv;
      nextLatch = !rstCond && (eqLat_q[evalIdx_q] || nextOut);
      if (gate == curOut || expire)
      begin
         cnt_d = clee_pkg::CNT_RST;
      end
      else
      begin
         cnt_d = curCnt + 16'h0001;
      end
   end

   // Evaluation index walks upward and wraps
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         evalIdx_q <= '0;
      end
      else if (evalIdx_q == IDX_LAST)
      begin
         evalIdx_q <= '0;
      end
      else
      begin
         evalIdx_q <= evalIdx_q + IDX_W'(1);
      end
   end

   // Pass-complete pulse
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         cycleDone_q <= 1'b0;
      end
      else
      begin
         cycleDone_q <= (evalIdx_q == IDX_LAST);
      end
   end

   // Delayed output and timer of the evaluated equation
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         eqOut_q <= '0;
         for (int i = 0; i < NUM_EQ; i++)
         begin
            eqCnt_q[i] <= clee_pkg::CNT_RST;
         end
      end
      else
      begin
         eqOut_q[evalIdx_q] <= nextOut;
         eqCnt_q[evalIdx_q] <= cnt_d;
      end
   end

   // Reset-dominant latch
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         eqLat_q <= '0;
      end
      else
      begin
         eqLat_q[evalIdx_q] <= nextLatch;
      end
   end

   // Status of conditioned inputs and raw gate
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         eqIn_q <= '0;
         eqGate_q <= '0;
      end
      else
      begin
         eqIn_q[evalIdx_q] <= condIn;
         eqGate_q[evalIdx_q] <= gate;
      end
   end

   assign eqOut = eqOut_q;
   assign eqLatched = eqLat_q;
   assign eqLatchedN = ~eqLat_q;
   assign eqInState = eqIn_q;
   assign eqGateState = eqGate_q;
   assign evalIndex = evalIdx_q;
   assign cycleDone = cycleDone_q;

   // Helpers for the checks
   logic [NUM_EQ-1:0] evalMask;
   assign evalMask = NUM_EQ'(1) << evalIdx_q;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         prevIdx_q <= '0;
      end
      else
      begin
         prevIdx_q <= evalIdx_q;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   chk_eval_order: assert property (
      evalIdx_q != IDX_LAST |=> evalIdx_q == $past(evalIdx_q) + IDX_W'(1))
      else $error("Evaluation index did not advance by one");

   chk_wrap_pulse: assert property (
      evalIdx_q == IDX_LAST |=> evalIdx_q == '0 && cycleDone ##1 !cycleDone)
      else $error("Wrap or pass pulse wrong");

   chk_others_hold: assert property (
      1'b1 |=> (eqOut_q & ~$past(evalMask)) ==
               ($past(eqOut_q) & ~$past(evalMask)))
      else $error("An unevaluated equation changed");

   chk_reset_wins: assert property (
      rstCond |=> !eqLatched[prevIdx_q] && eqLatchedN[prevIdx_q])
      else $error("Latch not cleared by reset");

   chk_latch_set: assert property (
      !rstCond && nextOut |=> eqLatched[prevIdx_q])
      else $error("Latch not set by delayed output");

   chk_zero_delay: assert property (
      gate != curOut && curDelay == '0 |=> eqOut[prevIdx_q] == $past(gate))
      else $error("Zero delay did not pass the gate");

   chk_delay_hold: assert property (
      gate != curOut && !expire |=> eqOut[prevIdx_q] == $past(curOut))
      else $error("Output changed before delay expired");

   chk_timer_restart: assert property (
      gate == curOut |=> eqCnt_q[prevIdx_q] == clee_pkg::CNT_RST)
      else $error("Timer not restarted");

   chk_status_in: assert property (
      1'b1 |=> eqInState[prevIdx_q] == $past(condIn)
               && eqGateState[prevIdx_q] == $past(gate))
      else $error("Input status not updated");

   chk_timer_count: assert property (
      gate != curOut && !expire |=>
         eqCnt_q[prevIdx_q] == $past(curCnt) + 16'h0001)
      else $error("Timer did not count up by one");

   chk_expire_flip: assert property (
      gate != curOut && expire |=> eqOut[prevIdx_q] == $past(gate)
               && eqCnt_q[prevIdx_q] == clee_pkg::CNT_RST)
      else $error("Expired timer did not move the output");

   chk_out_steady: assert property (
      gate == curOut |=> eqOut[prevIdx_q] == $past(curOut))
      else $error("Output moved with gate equal to it");

   chk_latch_hold: assert property (
      !rstCond && !nextOut |=>
         eqLatched[prevIdx_q] == $past(eqLat_q[evalIdx_q]))
      else $error("Latch changed with no set or reset");

   chk_latch_others: assert property (
      1'b1 |=> (eqLat_q & ~$past(evalMask)) ==
               ($past(eqLat_q) & ~$past(evalMask)))
      else $error("An unevaluated latch changed");

   chk_pulse_place: assert property (
      evalIdx_q != '0 |-> !cycleDone)
      else $error("Pass pulse away from index zero");

   chk_out_source: assert property (
      cfg.inSel[0] >= SRC_OUT_BASE && cfg.inSel[0] < SRC_LAT_BASE |->
         condIn[0] == (eqOut_q[cfg.inSel[0] - SRC_OUT_BASE] ^ cfg.inInv[0]))
      else $error("Unlatched output not routed as a source");

   chk_lat_source: assert property (
      cfg.inSel[0] >= SRC_LAT_BASE && cfg.inSel[0] < SRC_N |->
         condIn[0] == (eqLat_q[cfg.inSel[0] - SRC_LAT_BASE] ^ cfg.inInv[0]))
      else $error("Latched output not routed as a source");

   chk_refused_src: assert property (
      cfg.inSel[0] >= SRC_N |-> condIn[0] == cfg.inInv[0])
      else $error("Select beyond the list did not read zero");

   cov_reset_and_set: cover property (rstCond && nextOut);
   cov_delay_expire: cover property (
      gate != curOut && curDelay != '0 && expire);
   cov_full_pass: cover property (cycleDone);
   cov_latch_hold: cover property (
      eqLat_q[evalIdx_q] && !rstCond && !nextOut);

endmodule // clee_engine

// File: clee_src_model.sv
`timescale 1ns/1ps
// Protection and breaker status sources, updated on the process clock
module clee_src_model (
   input wire logic sys_clk,
   input wire logic [15:0] pickup,
   output logic [15:0] extSignal
);
   always_ff @(posedge sys_clk)
   begin
      extSignal <= pickup;
   end
endmodule // clee_src_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] pickup = 16'h0040;
   logic [15:0] extSignal;
   clee_pkg::clee_cfg_s eqCfg [8];
   logic [7:0] eqOut, eqLatched, eqLatchedN, eqGateState;
   logic [7:0][3:0] eqInState;
   logic [2:0] evalIndex;
   logic cycleDone;
   int errorCnt = 0;
   int comparisons = 0;
   int cyc = 0;
   initial forever #4 sys_clk = ~sys_clk;
   clee_src_model clee_src_model_i (.sys_clk(sys_clk), .pickup(pickup),
      .extSignal(extSignal));
   clee_engine clee_engine_i (.sys_clk(sys_clk), .rst(rst),
      .extSignal(extSignal), .eqCfg(eqCfg), .eqOut(eqOut),
      .eqLatched(eqLatched), .eqLatchedN(eqLatchedN),
      .eqInState(eqInState), .eqGateState(eqGateState),
      .evalIndex(evalIndex), .cycleDone(cycleDone));
   task automatic print_verdict;
      if (errorCnt == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic sync;
      int k;
      k = 0;
      do
      begin
         step(1);
         k++;
      end while (cycleDone !== 1'b1 && k < 20);
      chk({5'h00, evalIndex}, 8'h00);
   endtask
   task automatic set(input int i, input logic [23:0] sel,
      input logic [3:0] inv, input logic [1:0] op, input logic [15:0] rise,
      input logic [15:0] fall, input logic [5:0] rs, input logic ri);
      eqCfg[i] = '{sel, inv, clee_pkg::clee_gate_e'(op), rise, fall, rs, ri};
   endtask
   // Every gate operator over several input patterns, two inputs inverted
   task automatic test_gates;
      logic [3:0] v, c;
      logic e, lat;
      lat = 1'b0;
      set(0, {6'h03, 6'h02, 6'h01, 6'h00}, 4'h3, 2'h0, 16'h0000, 16'h0000,
         6'h3F, 1'b0);
      for (int op = 0; op < 4; op++)
      begin
         for (int j = 0; j < 3; j++)
         begin
            v = (j == 0) ? 4'h5 : (j == 1) ? 4'hC : 4'h3;
            eqCfg[0].gateOp = clee_pkg::clee_gate_e'(op);
            pickup[3:0] = v;
            step(24);
            c = v ^ 4'h3;
            e = (op == 0) ? &c : (op == 1) ? |c : (op == 2) ? ~&c : ~|c;
            lat = lat | e;
            chk({4'h0, eqInState[0]}, {4'h0, c});
            chk({7'h00, eqOut[0]}, {7'h00, e});
            chk({7'h00, eqGateState[0]}, {7'h00, e});
            chk({6'h00, eqLatched[0], eqLatchedN[0]},
               {6'h00, lat, ~lat});
         end
      end
   endtask
   // Eq2 feeds eq3 upward and eq1 downward, its latch feeds eq4
   task automatic test_cascade;
      set(2, {4{6'h04}}, 4'h0, 2'h1, 16'h0000, 16'h0000, 6'h3F, 1'b0);
      set(1, {4{6'h12}}, 4'h0, 2'h0, 16'h0000, 16'h0000, 6'h3F, 1'b0);
      set(3, {4{6'h12}}, 4'h0, 2'h0, 16'h0000, 16'h0000, 6'h3F, 1'b0);
      set(4, {4{6'h1A}}, 4'h0, 2'h1, 16'h0000, 16'h0000, 6'h3F, 1'b0);
      step(24);
      sync;
      pickup[4] = 1'b1;
      step(4);
      chk({5'h00, eqOut[3:1]}, 8'h06);
      step(8);
      chk({5'h00, eqOut[3:1]}, 8'h07);
      chk({7'h00, eqOut[4]}, 8'h01);
   endtask
   // Rise 2, fall 1, latch cleared by inverted source, reset beats set
   task automatic test_delay;
      set(5, {4{6'h05}}, 4'h0, 2'h1, 16'h0002, 16'h0001, 6'h06, 1'b1);
      step(24);
      sync;
      pickup[5] = 1'b1;
      step(6);
      chk({7'h00, eqOut[5]}, 8'h00);
      step(8);
      chk({7'h00, eqOut[5]}, 8'h00);
      step(8);
      chk({6'h00, eqOut[5], eqLatched[5]}, 8'h03);
      pickup[5] = 1'b0;
      step(8);
      chk({7'h00, eqOut[5]}, 8'h01);
      step(8);
      chk({6'h00, eqOut[5], eqLatched[5]}, 8'h01);
      pickup[6] = 1'b0;
      step(8);
      chk({6'h00, eqLatched[5], eqLatchedN[5]}, 8'h01);
      pickup[5] = 1'b1;
      step(24);
      chk({6'h00, eqOut[5], eqLatched[5]}, 8'h02);
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         errorCnt++;
         print_verdict;
      end
   end
   initial
   begin
      for (int i = 0; i < 8; i++)
         set(i, {4{6'h3F}}, 4'h0, 2'h0, 16'h0000, 16'h0000, 6'h3F, 1'b0);
      repeat (6) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      test_gates;
      test_cascade;
      test_delay;
      print_verdict;
   end
endmodule // testbench
